/* core/ipse_top.sv */
// interrupt page stack, extended enable mask and external input selection
`timescale 1ns/1ps
`default_nettype none
module ipse_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ipse_pkg::ipse_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic irq_entry,
   input wire logic irq_entry_can,
   input wire logic return_from_interrupt,
   input wire ipse_pkg::ipse_flags_t flags,
   input wire logic [7:0] port1_pins,
   input wire logic [7:0] port1_skip,
   input wire logic [7:0] port1_xbar_claim,
   output logic [7:0] port1_xbar_grant,
   output logic [7:0] page_select_current,
   output logic [7:0] page_stack_middle,
   output logic [7:0] page_stack_bottom,
   output logic [7:0] irq_req,
   output logic ext_irq_zero,
   output logic ext_irq_one
);
   import ipse_pkg::*;

   logic [7:0] cur_q;
   logic [7:0] mid_q;
   logic [7:0] bot_q;
   logic [7:0] en_q;
   logic [7:0] cfg_q;
   logic [7:0] rd_d;
   logic hit_d;
   logic cfg_sel;

   function automatic logic ext_level(input logic [7:0] pins, input logic [2:0] sel,
                                      input logic pol);
      ext_level = pins[sel] ^ ~pol; // [RL21]
   endfunction

   assign cfg_sel = (sfr_req.addr == ADDR_EXT_CFG) && (cur_q == PAGE_CFG); // [RL18] [RL19]

   // page stack; hardware events win over software stores in the same cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cur_q <= RST_PAGE;
         mid_q <= RST_PAGE;
         bot_q <= RST_PAGE;
      end else if (irq_entry) begin
         mid_q <= cur_q; // [RL2] [RL3]
         bot_q <= mid_q; // [RL3]
         cur_q <= irq_entry_can ? PAGE_CAN : PAGE_BASE; // [RL1] [RL7]
      end else if (return_from_interrupt) begin
         cur_q <= mid_q; // [RL4]
         mid_q <= bot_q; // [RL4]
         bot_q <= RST_PAGE; // [RL4]
      end else if (sfr_req.wr) begin
         // plain stores: no push or pop here
         if (sfr_req.addr == ADDR_PAGE_CUR) cur_q <= sfr_req.wdata; // [RL6]
         if (sfr_req.addr == ADDR_PAGE_MID) mid_q <= sfr_req.wdata; // [RL5]
         if (sfr_req.addr == ADDR_PAGE_BOT) bot_q <= sfr_req.wdata; // [RL5]
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         en_q <= RST_IRQ_EN; // [RL20]
      end else if (sfr_req.wr && sfr_req.addr == ADDR_IRQ_EN) begin
         en_q <= sfr_req.wdata; // [RL8] [RL9]
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= RST_EXT_CFG;
      end else if (sfr_req.wr && cfg_sel) begin
         cfg_q <= sfr_req.wdata; // [RL18]
      end
   end

   always_comb begin
      rd_d = 8'h00;
      hit_d = 1'b1;
      if (sfr_req.addr == ADDR_IRQ_EN) rd_d = en_q; // [RL9]
      else if (cfg_sel) rd_d = cfg_q; // [RL18]
      else if (sfr_req.addr == ADDR_PAGE_CUR) rd_d = cur_q;
      else if (sfr_req.addr == ADDR_PAGE_MID) rd_d = mid_q;
      else if (sfr_req.addr == ADDR_PAGE_BOT) rd_d = bot_q;
      else hit_d = 1'b0;
   end

   // read data is registered, so it appears one cycle after the address
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
      end else begin
         sfr_rdata <= sfr_req.rd ? rd_d : 8'h00;
         sfr_hit <= sfr_req.rd & hit_d;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_req <= 8'h00;
      end else begin
         irq_req[EN_LIN] <= flags.lin & en_q[EN_LIN]; // [RL8] [RL20]
         irq_req[EN_TMR3] <= (flags.tmr3_low | flags.tmr3_high) & en_q[EN_TMR3]; // [RL11]
         irq_req[EN_CMP1] <= (flags.cmp1_rise | flags.cmp1_fall) & en_q[EN_CMP1]; // [RL10]
         irq_req[EN_CMP0] <= (flags.cmp0_rise | flags.cmp0_fall) & en_q[EN_CMP0]; // [RL10]
         irq_req[EN_PCA] <= flags.pca & en_q[EN_PCA]; // [RL20]
         irq_req[EN_ADC_DONE] <= flags.adc_done & en_q[EN_ADC_DONE]; // [RL20]
         irq_req[EN_ADC_WIN] <= flags.adc_win & en_q[EN_ADC_WIN]; // [RL20]
         irq_req[EN_SMB] <= flags.smb & en_q[EN_SMB]; // [RL20]
      end
   end

   // monitoring only: the selection never feeds the crossbar grant
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_irq_zero <= 1'b0;
         ext_irq_one <= 1'b0;
      end else begin
         ext_irq_zero <= ext_level(port1_pins, cfg_q[EXT0_SEL_LO +: SEL_W],
                                   cfg_q[EXT0_POL]); // [RL14] [RL15] [RL16]
         ext_irq_one <= ext_level(port1_pins, cfg_q[EXT1_SEL_LO +: SEL_W],
                                  cfg_q[EXT1_POL]); // [RL12] [RL13] [RL16]
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         port1_xbar_grant <= 8'h00;
      end else begin
         port1_xbar_grant <= port1_xbar_claim & ~port1_skip; // [RL16] [RL17]
      end
   end

   assign page_select_current = cur_q;
   assign page_stack_middle = mid_q;
   assign page_stack_bottom = bot_q;
endmodule
`default_nettype wire

/* core/ipse_pkg.sv */
// package: constants and types for the interrupt page stack and enables block
// How it works
// RL1: on interrupt entry the current page becomes the source's flag page.
// RL2: three-entry page stack: current page, middle saved entry, bottom saved entry.
// RL3: entry pushes current into middle and middle into bottom before loading.
// RL4: return moves middle to current, bottom to middle; bottom then reads zero.
// RL5: software writes to middle and bottom are plain stores, never push or pop.
// RL6: stack moves only on interrupt entry and return events.
// RL7: vectoring selects page 0x00, except the CAN source which selects 0x0C.
// RL8: extended enable mask holds one enable bit per source, 1 enables.
// RL9: extended enable mask decodes at 0xE6 on every page.
// RL10: comparator request raised by its rising or falling flag when enabled.
// RL11: timer 3 request raised by low or high overflow flag when enabled.
// RL12: external input 1 polarity bit 7: 0 active low, 1 active high.
// RL13: external input 1 pin select bits 6:4 pick port 1 pin n.
// RL14: external input 0 polarity bit 3: 0 active low, 1 active high.
// RL15: external input 0 pin select bits 2:0 pick port 1 pin n.
// RL16: external inputs sample the selected pin without changing routing.
// RL17: a skipped pin is never given to a peripheral, even if selected.
// RL18: external interrupt configuration decodes at 0xE4 only on page 0x0F.
// RL19: three register pages exist: 0x00, 0x0C and 0x0F.
// RL20: each request is pending flag AND enable; enables clear at reset.
// RL21: external request is pin level XOR not polarity, active high.
package ipse_pkg;
   localparam logic [7:0] ADDR_PAGE_CUR = 8'hA7;
   localparam logic [7:0] ADDR_PAGE_MID = 8'h85;
   localparam logic [7:0] ADDR_PAGE_BOT = 8'h86;
   localparam logic [7:0] ADDR_EXT_CFG = 8'hE4;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hE6;
   localparam logic [7:0] PAGE_BASE = 8'h00;
   localparam logic [7:0] PAGE_CAN = 8'h0C;
   localparam logic [7:0] PAGE_CFG = 8'h0F;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [7:0] RST_EXT_CFG = 8'h00;
   localparam logic [7:0] RST_IRQ_EN = 8'h00;
   localparam int EN_LIN = 7;
   localparam int EN_TMR3 = 6;
   localparam int EN_CMP1 = 5;
   localparam int EN_CMP0 = 4;
   localparam int EN_PCA = 3;
   localparam int EN_ADC_DONE = 2;
   localparam int EN_ADC_WIN = 1;
   localparam int EN_SMB = 0;
   localparam int EXT1_POL = 7;
   localparam int EXT1_SEL_LO = 4;
   localparam int EXT0_POL = 3;
   localparam int EXT0_SEL_LO = 0;
   localparam int SEL_W = 3;

   typedef struct packed {
      logic lin;
      logic tmr3_low;
      logic tmr3_high;
      logic cmp1_rise;
      logic cmp1_fall;
      logic cmp0_rise;
      logic cmp0_fall;
      logic pca;
      logic adc_done;
      logic adc_win;
      logic smb;
   } ipse_flags_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ipse_sfr_req_t;
endpackage

/* testbench/ipse_core_model.sv */
// core model: issues interrupt entry and return pulses on command
`timescale 1ns/1ps
`default_nettype none
module ipse_core_model (
   input wire logic ref_clk,
   input wire logic take,
   input wire logic can,
   input wire logic give_back,
   output logic irq_entry = 1'h0,
   output logic irq_entry_can = 1'h0,
   output logic return_from_interrupt = 1'h0
);
   // source flag is only meaningful with entry; it toggles otherwise so nothing leans on it
   always @(posedge ref_clk) begin
      irq_entry <= take;
      return_from_interrupt <= give_back;
      irq_entry_can <= take ? can : ~irq_entry_can;
   end
endmodule
`default_nettype wire

/* testbench/ipse_chk_asserts.sv */
// checker: page stack, enable mask and pin routing assertions
`timescale 1ns/1ps
`default_nettype none
module ipse_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ipse_pkg::ipse_sfr_req_t sfr_req,
   input wire logic sfr_hit,
   input wire logic irq_entry,
   input wire logic irq_entry_can,
   input wire logic return_from_interrupt,
   input wire ipse_pkg::ipse_flags_t flags,
   input wire logic [7:0] port1_skip,
   input wire logic [7:0] port1_xbar_claim,
   input wire logic [7:0] port1_xbar_grant,
   input wire logic [7:0] page_select_current,
   input wire logic [7:0] page_stack_middle,
   input wire logic [7:0] page_stack_bottom,
   input wire logic [7:0] irq_req
);
   import ipse_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire pop = return_from_interrupt && !irq_entry;
   a_push_stack: assert property (irq_entry |=> page_stack_middle == $past(page_select_current)
      && page_stack_bottom == $past(page_stack_middle)) else $error("stack not pushed");
   a_entry_page: assert property (irq_entry |=>
      page_select_current == ($past(irq_entry_can) ? PAGE_CAN : PAGE_BASE)) else $error("bad page");
   a_pop_move: assert property (pop |=> page_select_current == $past(page_stack_middle)
      && page_stack_bottom == 8'h00) else $error("stack not popped");
   a_stack_hold: assert property (!irq_entry && !return_from_interrupt && !sfr_req.wr |=>
      $stable({page_select_current, page_stack_middle})) else $error("stack moved");
   a_soft_store: assert property (sfr_req.wr && sfr_req.addr == ADDR_PAGE_MID && !irq_entry
      && !return_from_interrupt |=> $stable(page_select_current)) else $error("store popped");
   a_tmr3_or: assert property (irq_req[EN_TMR3] |->
      $past(flags.tmr3_low || flags.tmr3_high)) else $error("timer request without flag");
   a_skip_grant: assert property (nrst |=>
      port1_xbar_grant == $past(port1_xbar_claim & ~port1_skip)) else $error("skipped pin given");
   a_mask_hit: assert property (sfr_req.rd && sfr_req.addr == ADDR_IRQ_EN |=> sfr_hit)
      else $error("mask read missed");
   c_can: cover property (irq_entry && irq_entry_can);
   c_pop: cover property (pop);
   c_tmr: cover property (irq_req[EN_TMR3]);
endmodule
bind ipse_top ipse_chk u_ipse_chk (.*);
`default_nettype wire

/* testbench/tb.sv */
// testbench: stack, enables and external input routing
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module tb;
   import ipse_pkg::*;
   logic ref_clk = 1'h0, nrst = 1'h0, take = 1'h0, can = 1'h0, give_back = 1'h0;
   logic irq_entry, irq_entry_can, return_from_interrupt, sfr_hit, ext_irq_zero, ext_irq_one;
   ipse_sfr_req_t sfr_req = '0;
   ipse_flags_t flags = '0;
   logic [7:0] port1_pins = '0, port1_skip = '0, port1_xbar_claim = 8'hFF;
   logic [7:0] sfr_rdata, port1_xbar_grant, page_select_current, page_stack_middle;
   logic [7:0] page_stack_bottom, irq_req;
   int checked = 0, fail_count = 0;
   ipse_top u_ipse_top (.*);
   ipse_core_model u_ipse_core_model (.*);
   initial forever #4 ref_clk = ~ref_clk;
   task automatic acc(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) sfr_req <= {op, a, d};
      @(posedge ref_clk) sfr_req <= '0;
      #1;
   endtask
   // model needs one edge to pulse, the block a second to act
   task automatic evt(input logic t, input logic c, input logic g);
      @(posedge ref_clk) begin take <= t; can <= c; give_back <= g; end
      @(posedge ref_clk) begin take <= 1'h0; give_back <= 1'h0; end
      @(posedge ref_clk);
      #1;
   endtask
   task automatic stk(input logic [7:0] c, input logic [7:0] m, input logic [7:0] b);
      `CK("cur", c, page_select_current)
      `CK("mid", m, page_stack_middle)
      `CK("bot", b, page_stack_bottom)
   endtask
   task automatic t_reset;
      acc(2'h1, ADDR_IRQ_EN, 8'h00);
      `CK("irq_en", 8'h00, sfr_rdata)
      stk(8'h00, 8'h00, 8'h00);
      acc(2'h2, ADDR_EXT_CFG, 8'hFF);
      acc(2'h1, ADDR_EXT_CFG, 8'h00);
      `CK("cfg_hit", 1'h0, sfr_hit)
   endtask
   task automatic t_stack;
      acc(2'h2, ADDR_PAGE_CUR, PAGE_CFG);
      acc(2'h2, ADDR_PAGE_MID, PAGE_CAN);
      evt(1'h1, 1'h0, 1'h0);
      stk(PAGE_BASE, PAGE_CFG, PAGE_CAN);
      evt(1'h1, 1'h1, 1'h0);
      stk(PAGE_CAN, PAGE_BASE, PAGE_CFG);
      acc(2'h2, ADDR_PAGE_MID, PAGE_CAN);
      acc(2'h2, ADDR_PAGE_BOT, PAGE_CFG);
      stk(PAGE_CAN, PAGE_CAN, PAGE_CFG);
      evt(1'h0, 1'h0, 1'h1);
      stk(PAGE_CAN, PAGE_CFG, 8'h00);
      evt(1'h0, 1'h0, 1'h1);
      stk(PAGE_CFG, 8'h00, 8'h00);
   endtask
   task automatic t_pins;
      logic [2:0] n;
      logic p;
      for (int i = 0; i < 16; i++) begin
         n = i[2:0];
         p = i[3];
         acc(2'h2, ADDR_EXT_CFG, {p, 3'h7 - n, p, n});
         @(posedge ref_clk) begin port1_pins <= 8'h01 << n; port1_skip <= 8'h01 << n; end
         repeat (2) @(posedge ref_clk);
         #1;
         `CK("ext0", p, ext_irq_zero)
         `CK("ext1", ~p, ext_irq_one)
         `CK("grant", ~(8'h01 << n), port1_xbar_grant)
      end
      acc(2'h1, ADDR_EXT_CFG, 8'h00);
      `CK("cfg", 8'h8F, sfr_rdata)
   endtask
   task automatic t_mask;
      @(posedge ref_clk) flags <= '1;
      for (int i = 0; i < 8; i++) begin
         acc(2'h2, ADDR_IRQ_EN, 8'h01 << i);
         @(posedge ref_clk);
         #1;
         `CK("req", 8'h01 << i, irq_req)
      end
      acc(2'h2, ADDR_IRQ_EN, 8'hFF);
      @(posedge ref_clk) flags <= 11'h240;
      repeat (2) @(posedge ref_clk);
      #1;
      `CK("req_or", 8'h60, irq_req)
      acc(2'h1, ADDR_IRQ_EN, 8'h00);
      `CK("en_rd", 8'hFF, sfr_rdata)
      `CK("en_hit", 1'h1, sfr_hit)
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'h1;
      t_reset;
      t_stack;
      t_pins;
      t_mask;
      give_verdict;
   end
endmodule
`default_nettype wire
